// ==== rtl/apic_regs.sv ====
// Audio power and input control register bank with volume shadowing.
// Assumes a host register port synchronous to clk_in; one access per cycle.
//
// How it works
// - Bit 8 or speaker output enables gain stage
// - Headphone mixer enables at bits five, four
// - Bit 3 enables speaker mixer, reset off
// - Clock bit 15 picks test clock f/2 or f/1
// - First line bit 1 selects differential mode
// - First line bit 0 clamps pads, reset on
// - Second line bit 1 selects differential mode
// - Second line bit 0 clamps pads, reset on
// - A update bit applies both volumes together
// - Bit 6 defers gain to zero crossing
// - Differential volume code maps -6 to +18 dB
// - Single-ended code maps 0 to +24 dB
// - B update bit applies both volumes too
`timescale 1ns/1ps

module apic_regs
	import apic_pkg::*;
#(
	parameter int TCLK_SRC_DIV = APIC_TCLK_SRC_DIV
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	// Analogue status
	input wire logic speaker_output_enable_in,
	input wire logic first_input_a_zero_cross_in,
	input wire logic first_input_b_zero_cross_in,
	// Power enables
	output apic_power_t power_out,
	// Test clock
	output logic test_clock_output_out,
	// Line inputs
	output logic first_input_differential_select_out,
	output logic first_input_pad_clamp_out,
	output logic second_input_differential_select_out,
	output logic second_input_pad_clamp_out,
	// Applied gain stage settings
	output apic_stage_t first_input_a_stage_out,
	output apic_stage_t first_input_b_stage_out
);

	// Gain in half-dB steps for a code under the chosen input configuration
	function automatic logic signed [6:0] vol_to_half_db(input logic [2:0] code,
			input logic diff);
		logic signed [6:0] g;
		g = 7'sd0;
		if (diff) begin
			case (code)
				3'h0: g = -7'sd12;
				3'h1: g = -7'sd7;
				3'h2: g = 7'sd0;
				3'h3: g = 7'sd7;
				3'h4: g = 7'sd12;
				3'h5: g = 7'sd24;
				default: g = 7'sd36;
			endcase
		end else begin
			case (code)
				3'h0: g = 7'sd0;
				3'h1: g = 7'sd5;
				3'h2: g = 7'sd12;
				3'h3: g = 7'sd19;
				3'h4: g = 7'sd24;
				3'h5: g = 7'sd36;
				default: g = 7'sd48;
			endcase
		end
		return g;
	endfunction

	logic gain_limiter_r;
	logic spk_gain_stage_r;
	logic left_hp_mixer_r;
	logic right_hp_mixer_r;
	logic spk_mixer_r;
	logic tclk_div_sel_r;
	logic tclk_enable_r;
	logic first_diff_r;
	logic first_clamp_r;
	logic second_diff_r;
	logic second_clamp_r;
	apic_vol_reg_t vol_a_r;
	apic_vol_reg_t vol_b_r;
	logic [2:0] staged_a_r;
	logic [2:0] staged_b_r;
	logic wait_a_r;
	logic wait_b_r;
	logic [2:0] applied_a_r;
	logic [2:0] applied_b_r;

	wire logic wr_power = reg_wr_in && (reg_addr_in == APIC_ADDR_POWER_THREE);
	wire logic wr_tclk = reg_wr_in && (reg_addr_in == APIC_ADDR_TEST_CLOCK);
	wire logic wr_first = reg_wr_in && (reg_addr_in == APIC_ADDR_FIRST_LINE);
	wire logic wr_second = reg_wr_in && (reg_addr_in == APIC_ADDR_SECOND_LINE);
	wire logic wr_vol_a = reg_wr_in && (reg_addr_in == APIC_ADDR_FIRST_A_VOL);
	wire logic wr_vol_b = reg_wr_in && (reg_addr_in == APIC_ADDR_FIRST_B_VOL);
	wire apic_vol_reg_t wdata_vol = '{mute: reg_wdata_in[APIC_BIT_MUTE],
		zero_cross: reg_wdata_in[APIC_BIT_ZERO_CROSS],
		vol: reg_wdata_in[APIC_VOL_MSB:APIC_VOL_LSB]};
	// Either volume register's update bit moves both stages
	wire logic vol_update = (wr_vol_a || wr_vol_b)
		&& reg_wdata_in[APIC_BIT_VOL_UPDATE];

	// Power register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gain_limiter_r <= APIC_RST_POWER_BIT;
			spk_gain_stage_r <= APIC_RST_POWER_BIT;
			left_hp_mixer_r <= APIC_RST_POWER_BIT;
			right_hp_mixer_r <= APIC_RST_POWER_BIT;
			spk_mixer_r <= APIC_RST_POWER_BIT;
		end else if (wr_power) begin
			gain_limiter_r <= reg_wdata_in[APIC_BIT_GAIN_LIMITER];
			spk_gain_stage_r <= reg_wdata_in[APIC_BIT_SPK_GAIN_STAGE];
			left_hp_mixer_r <= reg_wdata_in[APIC_BIT_LEFT_HP_MIXER];
			right_hp_mixer_r <= reg_wdata_in[APIC_BIT_RIGHT_HP_MIXER];
			spk_mixer_r <= reg_wdata_in[APIC_BIT_SPK_MIXER];
		end
	end

	// Power outputs, registered so the speaker override also comes from a flop
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			power_out <= '0;
		end else begin
			power_out.gain_limiter_enable <= gain_limiter_r;
			power_out.speaker_gain_stage_enable <= spk_gain_stage_r
				|| speaker_output_enable_in;
			power_out.left_headphone_mixer_enable <= left_hp_mixer_r;
			power_out.right_headphone_mixer_enable <= right_hp_mixer_r;
			power_out.speaker_mixer_enable <= spk_mixer_r
				|| speaker_output_enable_in;
		end
	end

	// Test clock control
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tclk_div_sel_r <= APIC_RST_TCLK_BIT;
			tclk_enable_r <= APIC_RST_TCLK_BIT;
		end else if (wr_tclk) begin
			tclk_div_sel_r <= reg_wdata_in[APIC_BIT_TCLK_DIV_SEL];
			tclk_enable_r <= reg_wdata_in[APIC_BIT_TCLK_ENABLE];
		end
	end

	// Test clock generator: the source f is a tick every TCLK_SRC_DIV clocks;
	// the output toggles on each tick (f/1) or on every second tick (f/2)
	localparam int TCLK_CNT_W = (TCLK_SRC_DIV > 1) ? $clog2(TCLK_SRC_DIV) : 1;
	localparam logic [TCLK_CNT_W-1:0] TCLK_CNT_LAST = TCLK_CNT_W'(TCLK_SRC_DIV - 1);
	logic [TCLK_CNT_W-1:0] tclk_cnt_r;
	logic tclk_half_r;
	logic tclk_tick;

	assign tclk_tick = (tclk_cnt_r == TCLK_CNT_LAST);

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tclk_cnt_r <= '0;
			tclk_half_r <= 1'b0;
			test_clock_output_out <= 1'b0;
		end else if (!tclk_enable_r) begin
			// Held low and phase-reset so enabling starts a clean period
			tclk_cnt_r <= '0;
			tclk_half_r <= 1'b0;
			test_clock_output_out <= 1'b0;
		end else begin
			tclk_cnt_r <= tclk_tick ? '0 : tclk_cnt_r + 1'b1;
			if (tclk_tick) begin
				tclk_half_r <= !tclk_half_r;
				if (tclk_div_sel_r || tclk_half_r) begin
					test_clock_output_out <= !test_clock_output_out;
				end
			end
		end
	end

	// Line input control
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			first_diff_r <= APIC_RST_DIFF;
			first_clamp_r <= APIC_RST_CLAMP;
			second_diff_r <= APIC_RST_DIFF;
			second_clamp_r <= APIC_RST_CLAMP;
		end else begin
			if (wr_first) begin
				first_diff_r <= reg_wdata_in[APIC_BIT_DIFF_SELECT];
				first_clamp_r <= reg_wdata_in[APIC_BIT_PAD_CLAMP];
			end
			if (wr_second) begin
				second_diff_r <= reg_wdata_in[APIC_BIT_DIFF_SELECT];
				second_clamp_r <= reg_wdata_in[APIC_BIT_PAD_CLAMP];
			end
		end
	end

	assign first_input_differential_select_out = first_diff_r;
	assign first_input_pad_clamp_out = first_clamp_r;
	assign second_input_differential_select_out = second_diff_r;
	assign second_input_pad_clamp_out = second_clamp_r;

	// Volume registers: the field is a shadow, the update bit is not stored
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			vol_a_r <= '{mute: APIC_RST_MUTE, zero_cross: APIC_RST_ZERO_CROSS,
				vol: APIC_RST_VOL};
			vol_b_r <= '{mute: APIC_RST_MUTE, zero_cross: APIC_RST_ZERO_CROSS,
				vol: APIC_RST_VOL};
		end else begin
			if (wr_vol_a) begin
				vol_a_r <= wdata_vol;
			end
			if (wr_vol_b) begin
				vol_b_r <= wdata_vol;
			end
		end
	end

	// Update staging. The value copied is the shadow after this write, so a
	// write that carries both a new field and the update bit applies it.
	wire logic [2:0] next_a = wr_vol_a ? wdata_vol.vol : vol_a_r.vol;
	wire logic [2:0] next_b = wr_vol_b ? wdata_vol.vol : vol_b_r.vol;
	wire logic next_zc_a = wr_vol_a ? wdata_vol.zero_cross : vol_a_r.zero_cross;
	wire logic next_zc_b = wr_vol_b ? wdata_vol.zero_cross : vol_b_r.zero_cross;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			staged_a_r <= APIC_RST_VOL;
			staged_b_r <= APIC_RST_VOL;
			wait_a_r <= 1'b0;
			wait_b_r <= 1'b0;
			applied_a_r <= APIC_RST_VOL;
			applied_b_r <= APIC_RST_VOL;
		end else begin
			// A fresh update wins over a zero crossing in the same cycle
			if (vol_update) begin
				staged_a_r <= next_a;
				staged_b_r <= next_b;
				wait_a_r <= next_zc_a;
				wait_b_r <= next_zc_b;
				if (!next_zc_a) begin
					applied_a_r <= next_a;
				end
				if (!next_zc_b) begin
					applied_b_r <= next_b;
				end
			end else begin
				if (wait_a_r && first_input_a_zero_cross_in) begin
					applied_a_r <= staged_a_r;
					wait_a_r <= 1'b0;
				end
				if (wait_b_r && first_input_b_zero_cross_in) begin
					applied_b_r <= staged_b_r;
					wait_b_r <= 1'b0;
				end
			end
		end
	end

	localparam apic_stage_t STAGE_RST = '{mute: APIC_RST_MUTE, code: APIC_RST_VOL,
		gain_half_db: vol_to_half_db(APIC_RST_VOL, APIC_RST_DIFF)};

	// Stage outputs; mute acts directly and is not shadowed
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			first_input_a_stage_out <= STAGE_RST;
			first_input_b_stage_out <= STAGE_RST;
		end else begin
			first_input_a_stage_out <= '{mute: vol_a_r.mute, code: applied_a_r,
				gain_half_db: vol_to_half_db(applied_a_r, first_diff_r)};
			first_input_b_stage_out <= '{mute: vol_b_r.mute, code: applied_b_r,
				gain_half_db: vol_to_half_db(applied_b_r, first_diff_r)};
		end
	end

	// Read-back; undefined bits and unmapped offsets give zero
	logic [15:0] rd_word;

	always_comb begin
		rd_word = '0;
		case (reg_addr_in)
			APIC_ADDR_POWER_THREE: begin
				rd_word[APIC_BIT_GAIN_LIMITER] = gain_limiter_r;
				rd_word[APIC_BIT_SPK_GAIN_STAGE] = spk_gain_stage_r;
				rd_word[APIC_BIT_LEFT_HP_MIXER] = left_hp_mixer_r;
				rd_word[APIC_BIT_RIGHT_HP_MIXER] = right_hp_mixer_r;
				rd_word[APIC_BIT_SPK_MIXER] = spk_mixer_r;
			end
			APIC_ADDR_TEST_CLOCK: begin
				rd_word[APIC_BIT_TCLK_DIV_SEL] = tclk_div_sel_r;
				rd_word[APIC_BIT_TCLK_ENABLE] = tclk_enable_r;
			end
			APIC_ADDR_FIRST_LINE: begin
				rd_word[APIC_BIT_DIFF_SELECT] = first_diff_r;
				rd_word[APIC_BIT_PAD_CLAMP] = first_clamp_r;
			end
			APIC_ADDR_SECOND_LINE: begin
				rd_word[APIC_BIT_DIFF_SELECT] = second_diff_r;
				rd_word[APIC_BIT_PAD_CLAMP] = second_clamp_r;
			end
			APIC_ADDR_FIRST_A_VOL: begin
				rd_word[APIC_BIT_MUTE] = vol_a_r.mute;
				rd_word[APIC_BIT_ZERO_CROSS] = vol_a_r.zero_cross;
				rd_word[APIC_VOL_MSB:APIC_VOL_LSB] = vol_a_r.vol;
			end
			APIC_ADDR_FIRST_B_VOL: begin
				rd_word[APIC_BIT_MUTE] = vol_b_r.mute;
				rd_word[APIC_BIT_ZERO_CROSS] = vol_b_r.zero_cross;
				rd_word[APIC_VOL_MSB:APIC_VOL_LSB] = vol_b_r.vol;
			end
			default: rd_word = '0;
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			reg_rdata_out <= rd_word;
		end
	end

endmodule

// ==== rtl/apic_pkg.sv ====
// Package for the audio power and input control register bank.
// Assumes a host that moves 16-bit words at the printed register offsets.
package apic_pkg;

	// Register offsets, as printed
	localparam logic [7:0] APIC_ADDR_POWER_THREE = 8'h03;
	localparam logic [7:0] APIC_ADDR_TEST_CLOCK = 8'h06;
	localparam logic [7:0] APIC_ADDR_FIRST_LINE = 8'h16;
	localparam logic [7:0] APIC_ADDR_SECOND_LINE = 8'h17;
	localparam logic [7:0] APIC_ADDR_FIRST_A_VOL = 8'h18;
	localparam logic [7:0] APIC_ADDR_FIRST_B_VOL = 8'h19;

	// Power register fields
	localparam int APIC_BIT_GAIN_LIMITER = 14;
	localparam int APIC_BIT_SPK_GAIN_STAGE = 8;
	localparam int APIC_BIT_LEFT_HP_MIXER = 5;
	localparam int APIC_BIT_RIGHT_HP_MIXER = 4;
	localparam int APIC_BIT_SPK_MIXER = 3;

	// Test clock register fields
	localparam int APIC_BIT_TCLK_DIV_SEL = 15;
	localparam int APIC_BIT_TCLK_ENABLE = 14;

	// Line control fields
	localparam int APIC_BIT_DIFF_SELECT = 1;
	localparam int APIC_BIT_PAD_CLAMP = 0;

	// Volume register fields
	localparam int APIC_BIT_VOL_UPDATE = 8;
	localparam int APIC_BIT_MUTE = 7;
	localparam int APIC_BIT_ZERO_CROSS = 6;
	localparam int APIC_VOL_MSB = 2;
	localparam int APIC_VOL_LSB = 0;

	// Reset values
	localparam logic APIC_RST_POWER_BIT = 1'b0;
	localparam logic APIC_RST_TCLK_BIT = 1'b0;
	localparam logic APIC_RST_DIFF = 1'b1;
	localparam logic APIC_RST_CLAMP = 1'b1;
	localparam logic APIC_RST_MUTE = 1'b1;
	localparam logic APIC_RST_ZERO_CROSS = 1'b0;
	localparam logic [2:0] APIC_RST_VOL = 3'h3;

	// Test clock source: one source tick every this many system clocks
	localparam int APIC_TCLK_SRC_DIV = 2;

	// One gain stage as seen by the analogue side; gain in half-dB steps
	typedef struct packed {
		logic mute;
		logic [2:0] code;
		logic signed [6:0] gain_half_db;
	} apic_stage_t;

	// Power enables driven to the analogue side
	typedef struct packed {
		logic gain_limiter_enable;
		logic speaker_gain_stage_enable;
		logic left_headphone_mixer_enable;
		logic right_headphone_mixer_enable;
		logic speaker_mixer_enable;
	} apic_power_t;

	// Settings held per volume register
	typedef struct packed {
		logic mute;
		logic zero_cross;
		logic [2:0] vol;
	} apic_vol_reg_t;

endpackage

// ==== test/apic_regs_sva.sv ====
// Checker for the audio power and input control register bank.
// Sees only the bank's ports; a single clock domain.
`timescale 1ns/1ps
module apic_regs_sva
	import apic_pkg::*;
#(
	parameter int TCLK_SRC_DIV = APIC_TCLK_SRC_DIV
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	// Analogue side
	input wire logic speaker_output_enable_in,
	input wire logic first_input_a_zero_cross_in,
	input wire apic_power_t power_out,
	input wire logic first_input_differential_select_out,
	input wire logic first_input_pad_clamp_out,
	input wire apic_stage_t first_input_a_stage_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	wire logic w18 = reg_wr_in && reg_addr_in == 8'h18;
	wire logic [2:0] code_a = first_input_a_stage_out.code;
	property p_unmap;
		reg_rd_in && !(reg_addr_in inside {8'h03, 8'h06, [8'h16:8'h19]}) |=> reg_rdata_out == 16'h0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_vu0;
		reg_rd_in && reg_addr_in == 8'h18 |=> !reg_rdata_out[8];
	endproperty
	a_vu0: assert property (p_vu0) else $error("update bit read back");
	property p_spk;
		speaker_output_enable_in |=> power_out.speaker_gain_stage_enable && power_out.speaker_mixer_enable;
	endproperty
	a_spk: assert property (p_spk) else $error("speaker override missing");
	property p_mute;
		w18 ##1 !w18 |=> first_input_a_stage_out.mute == $past(reg_wdata_in[7], 2);
	endproperty
	a_mute: assert property (p_mute) else $error("mute not applied");
	property p_vu;
		w18 && reg_wdata_in[8] && !reg_wdata_in[6] ##1 !reg_wr_in |=> code_a == $past(reg_wdata_in[2:0], 2);
	endproperty
	a_vu: assert property (p_vu) else $error("volume update not applied");
	property p_shadow;
		w18 && !reg_wdata_in[8] && !first_input_a_zero_cross_in |=> ##1 $stable(code_a);
	endproperty
	a_shadow: assert property (p_shadow) else $error("volume leaked past shadow");
	property p_line1;
		reg_wr_in && reg_addr_in == 8'h16 |=> {first_input_differential_select_out,
			first_input_pad_clamp_out} == $past(reg_wdata_in[1:0]);
	endproperty
	a_line1: assert property (p_line1) else $error("line control mismatch");
	property p_pwr;
		reg_wr_in && reg_addr_in == 8'h03 ##1 !reg_wr_in |=> {power_out.gain_limiter_enable,
			power_out.left_headphone_mixer_enable, power_out.right_headphone_mixer_enable}
			== {$past(reg_wdata_in[14], 2), $past(reg_wdata_in[5], 2), $past(reg_wdata_in[4], 2)};
	endproperty
	a_pwr: assert property (p_pwr) else $error("power enable mismatch");
	c_upd: cover property (w18 && reg_wdata_in[8]);
	c_zc: cover property (first_input_a_zero_cross_in && code_a == 3'h6);
	c_spk: cover property (speaker_output_enable_in);
endmodule

bind apic_regs apic_regs_sva #(.TCLK_SRC_DIV(TCLK_SRC_DIV)) u_apic_regs_sva (.clk_in(clk_in),
	.arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.speaker_output_enable_in(speaker_output_enable_in), .power_out(power_out),
	.first_input_a_zero_cross_in(first_input_a_zero_cross_in),
	.first_input_differential_select_out(first_input_differential_select_out),
	.first_input_pad_clamp_out(first_input_pad_clamp_out),
	.first_input_a_stage_out(first_input_a_stage_out));

// ==== test/apic_host.sv ====
// Host model on the bank's register strobe port.
// Assumes one strobe cycle per access and read data one edge later.
`timescale 1ns/1ps
module apic_host (
	// Clock
	input wire logic clk_in,
	// Register port
	output logic [7:0] reg_addr_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [15:0] reg_wdata_out,
	input wire logic [15:0] reg_rdata_in
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_wdata_out = 16'h0000;
	end
	task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk_in);
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge clk_in);
		reg_wr_out = 1'b0;
		// Released data shows the inverse, so a stale word cannot pass
		reg_wdata_out = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
		@(negedge clk_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge clk_in);
		reg_rd_out = 1'b0;
		d = reg_rdata_in;
	endtask
endmodule

// ==== test/apic_regs_tb.sv ====
// Bench for the register bank, driven through the host model.
// Assumes the default test clock source divider of two clocks.
`timescale 1ns/1ps
module apic_regs_tb;
	import apic_pkg::*;
	logic clk_in, arst_n_in, spk, zc, tclk, wr, rd, p, d1, c1, d2, c2;
	logic [7:0] addr;
	logic [15:0] wdata, rdata, got;
	apic_power_t pwr;
	apic_stage_t st_a, st_b;
	logic [6:0] g_d [8] = '{7'h74, 7'h79, 7'h00, 7'h07, 7'h0c, 7'h18, 7'h24, 7'h24};
	logic [6:0] g_s [8] = '{7'h00, 7'h05, 7'h0c, 7'h13, 7'h18, 7'h24, 7'h30, 7'h30};
	int err_count, num_checks, cyc, n;
	apic_regs u_apic_regs (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.speaker_output_enable_in(spk), .first_input_a_zero_cross_in(zc),
		.first_input_b_zero_cross_in(zc), .power_out(pwr), .test_clock_output_out(tclk),
		.first_input_differential_select_out(d1), .first_input_pad_clamp_out(c1),
		.second_input_differential_select_out(d2), .second_input_pad_clamp_out(c2),
		.first_input_a_stage_out(st_a), .first_input_b_stage_out(st_b));
	apic_host u_apic_host (.clk_in(clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
		.reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic print_verdict();
		$display("Errors %0d of %0d checks", err_count, num_checks);
		if (err_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles the sequence needs
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			print_verdict();
		end
	end
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr_r(input logic [7:0] a, input logic [15:0] d);
		u_apic_host.write_reg(a, d);
	endtask
	task automatic rd_c(input logic [7:0] a, input logic [15:0] e);
		u_apic_host.read_reg(a, got);
		cmp(got, e);
	endtask
	task automatic wait_n(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	task automatic tclk_rate(input logic [15:0] d, input int e);
		wr_r(8'h06, d);
		wait_n(8);
		n = 0;
		repeat (32) begin
			p = tclk;
			@(negedge clk_in);
			n += int'(tclk !== p);
		end
		cmp(16'(n), 16'(e));
	endtask
	initial begin
		arst_n_in = 1'b0;
		spk = 1'b0;
		zc = 1'b0;
		wait_n(10);
		arst_n_in = 1'b1;
		rd_c(8'h03, 16'h0000);
		rd_c(8'h06, 16'h0000);
		rd_c(8'h16, 16'h0003);
		rd_c(8'h17, 16'h0003);
		rd_c(8'h18, 16'h0083);
		cmp(16'(st_a), 16'h0587);
		cmp(16'({d1, c1, d2, c2}), 16'h000f);
		wr_r(8'h20, 16'hffff);
		rd_c(8'h20, 16'h0000);
		wr_r(8'h03, 16'hffff);
		rd_c(8'h03, 16'h4138);
		wr_r(8'h16, 16'hfffc);
		rd_c(8'h16, 16'h0000);
		wr_r(8'h17, 16'hffff);
		rd_c(8'h17, 16'h0003);
		cmp(16'({d1, c1, d2, c2}), 16'h0003);
		wr_r(8'h18, 16'hfeff);
		rd_c(8'h18, 16'h00c7);
		wr_r(8'h18, 16'hffff);
		rd_c(8'h18, 16'h00c7);
		for (int m = 0; m < 2; m++) begin
			wr_r(8'h16, (m == 0) ? 16'h0002 : 16'h0000);
			for (int v = 0; v < 8; v++) begin
				wr_r(8'h18, {13'h0020, v[2:0]});
				wait_n(1);
				cmp(16'(st_a), {6'h00, v[2:0], (m == 0) ? g_d[v] : g_s[v]});
			end
		end
		wr_r(8'h19, 16'h0005);
		wait_n(1);
		cmp(16'(st_b.code), 16'h0003);
		wr_r(8'h18, 16'h0100);
		wait_n(1);
		cmp(16'(st_b), 16'h02a4);
		wr_r(8'h19, 16'h0102);
		wait_n(1);
		cmp(16'(st_b.code), 16'h0002);
		wr_r(8'h18, 16'h0146);
		wait_n(3);
		cmp(16'(st_a), 16'h0000);
		zc = 1'b1;
		wait_n(1);
		zc = 1'b0;
		wait_n(1);
		cmp(16'(st_a), 16'h0330);
		wr_r(8'h03, 16'h0000);
		wait_n(1);
		cmp(16'(pwr), 16'h0000);
		spk = 1'b1;
		wait_n(2);
		cmp(16'(pwr), 16'h0009);
		spk = 1'b0;
		wr_r(8'h03, 16'h0108);
		wait_n(1);
		cmp(16'(pwr), 16'h0009);
		tclk_rate(16'h4000, 8);
		tclk_rate(16'hc000, 16);
		tclk_rate(16'h8000, 0);
		print_verdict();
	end
endmodule
